/* File: hdl/dma_desc_ctrl.sv */
// Descriptor-mode DMA channel control: AHB-Lite register slave and single-channel mover
`timescale 1ns/1ns
module dma_desc_ctrl
  import dma_desc_pkg::*;
#(
  parameter int CNT_W = COUNT_W,
  parameter int DCNT_W = DESC_COUNT_W,
  parameter int BURST_LEN = BURST_ITEMS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic desc_go,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  output logic mem_lock,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic xfer_irq
);
  localparam int BEAT_W = (BURST_LEN > 1) ? $clog2(BURST_LEN) : 1;
  localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(BURST_LEN - 1);

  generate
    if (CNT_W < 1 || CNT_W > 32 || DCNT_W < 1 || DCNT_W > CNT_W) begin : g_bad_cnt
      $error("dma_desc_ctrl: count widths out of range");
    end
    if (BURST_LEN < 2 || (BURST_LEN & (BURST_LEN - 1)) != 0) begin : g_bad_burst
      $error("dma_desc_ctrl: burst length must be a power of two");
    end
  endgenerate

  typedef struct packed {
    logic src_mis;
    logic dst_mis;
    logic auto_reinit_en;
    logic bus_lock;
    logic [1:0] xfer_width_sel;
    logic desc_irq_sel;
    logic src_hold;
    logic dst_hold;
    logic src_step_dir;
    logic dst_step_dir;
    logic [1:0] channel_mode_sel;
    logic burst8_en;
    logic channel_en;
    logic desc_mode;
    logic desc_last;
    logic [1:0] kind;
    logic [31:0] src_base;
    logic [31:0] dst_base;
    logic [CNT_W-1:0] xfer_count;
    logic [31:0] cur_src;
    logic [31:0] cur_dst;
    logic [CNT_W-1:0] remain;
    logic [BEAT_W-1:0] beat;
    fsm_t fsm;
    logic wr_pend;
    logic [7:0] wr_ofs;
    logic [31:0] rdata;
    logic req;
    logic we;
    logic [31:0] addr;
    logic [1:0] size;
    logic [31:0] wdata;
    logic lock;
    logic irq;
  } state_t;

  state_t q;
  state_t d;

  // Step size in bytes for the chosen width
  function automatic logic [31:0] step_of(input logic [1:0] w);
    logic [2:0] s;
    s = STEP_BYTE;
    case (w)
      WID_HALF: s = STEP_HALF;
      WID_WORD: s = STEP_WORD;
      default: s = STEP_BYTE;
    endcase
    return {29'h0000_0000, s};
  endfunction

  // Next address after one operation
  function automatic logic [31:0] next_addr(input logic [31:0] a, input logic hold, input logic dir,
                                            input logic [1:0] w);
    logic [31:0] n;
    n = a;
    if (!hold) begin
      if (dir) begin
        n = a - step_of(w);
      end else begin
        n = a + step_of(w);
      end
    end
    return n;
  endfunction

  // Base address is off the width boundary
  function automatic logic misaligned(input logic [31:0] a, input logic [1:0] w);
    logic m;
    m = 1'b0;
    case (w)
      WID_WORD: m = (a[1:0] != 2'h0);
      WID_HALF: m = a[0];
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  function automatic logic [31:0] ctrl_word(input state_t s);
    logic [31:0] r;
    r = RESET_WORD;
    r[B_SRC_MIS] = s.src_mis;
    r[B_DST_MIS] = s.dst_mis;
    r[B_AUTO] = s.auto_reinit_en;
    r[B_LOCK] = s.bus_lock;
    r[B_WID_HI:B_WID_LO] = s.xfer_width_sel;
    r[B_IRQ_SEL] = s.desc_irq_sel;
    r[B_SRC_HOLD] = s.src_hold;
    r[B_DST_HOLD] = s.dst_hold;
    r[B_SRC_DIR] = s.src_step_dir;
    r[B_DST_DIR] = s.dst_step_dir;
    r[B_MODE_HI:B_MODE_LO] = s.channel_mode_sel;
    r[B_BURST] = s.burst8_en;
    r[B_EN] = s.channel_en;
    return r;
  endfunction

  function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] ofs);
    logic [31:0] r;
    r = RESET_WORD;
    case (ofs)
      OFS_CTRL: r = ctrl_word(s);
      OFS_SRC_BASE: r = s.src_base;
      OFS_DST_BASE: r = s.dst_base;
      OFS_COUNT: r = 32'(s.xfer_count);
      OFS_CUR_SRC: r = s.cur_src;
      OFS_CUR_DST: r = s.cur_dst;
      OFS_EXT: begin
        r[B_DESC_MODE] = s.desc_mode;
        r[B_DESC_LAST] = s.desc_last;
        r[B_KIND_HI:B_KIND_LO] = s.kind;
        r[B_BUSY] = (s.fsm != ST_IDLE);
      end
      default: r = RESET_WORD;
    endcase
    return r;
  endfunction

  logic addr_phase;
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_comb begin
    logic [CNT_W-1:0] load_cnt;
    logic item_done;
    logic start_ok;
    logic ch_reset;
    load_cnt = '0;
    item_done = 1'b0;
    start_ok = 1'b0;
    ch_reset = 1'b0;
    d = q;
    d.irq = 1'b0;

    // Register writes land in the data phase
    if (q.wr_pend) begin
      case (q.wr_ofs)
        OFS_CTRL: begin
          // Flag bits are not taken from hwdata
          d.auto_reinit_en = hwdata[B_AUTO];
          d.bus_lock = hwdata[B_LOCK];
          d.xfer_width_sel = hwdata[B_WID_HI:B_WID_LO];
          d.desc_irq_sel = hwdata[B_IRQ_SEL];
          d.src_hold = hwdata[B_SRC_HOLD];
          d.dst_hold = hwdata[B_DST_HOLD];
          d.src_step_dir = hwdata[B_SRC_DIR];
          d.dst_step_dir = hwdata[B_DST_DIR];
          d.channel_mode_sel = hwdata[B_MODE_HI:B_MODE_LO];
          d.burst8_en = hwdata[B_BURST];
          d.channel_en = hwdata[B_EN];
        end
        OFS_SRC_BASE: d.src_base = hwdata;
        OFS_DST_BASE: d.dst_base = hwdata;
        OFS_COUNT: d.xfer_count = hwdata[CNT_W-1:0];
        OFS_EXT: begin
          d.desc_mode = hwdata[B_DESC_MODE];
          d.desc_last = hwdata[B_DESC_LAST];
          d.kind = hwdata[B_KIND_HI:B_KIND_LO];
          ch_reset = hwdata[B_CH_RESET];
        end
        default: d.wr_pend = 1'b0;
      endcase
    end
    d.wr_pend = addr_phase && hwrite;
    d.wr_ofs = haddr[7:0];
    if (addr_phase && !hwrite) begin
      d.rdata = read_mux(q, haddr[7:0]);
    end

    // Descriptor mode keeps only the low count bits
    if (q.desc_mode) begin
      load_cnt = CNT_W'(q.xfer_count[DCNT_W-1:0]);
    end else begin
      load_cnt = q.xfer_count;
    end
    if (q.desc_mode) begin
      start_ok = (q.kind == KIND_IO2M) || desc_go;
    end else begin
      start_ok = 1'b1;
    end

    case (q.fsm)
      ST_IDLE: begin
        // Reserved width never starts a transfer
        if (q.channel_en && start_ok && q.xfer_width_sel != WID_RSVD) begin
          d.cur_src = q.src_base;
          d.cur_dst = q.dst_base;
          d.remain = load_cnt;
          d.beat = '0;
          if (load_cnt == '0) begin
            d.fsm = ST_DONE;
          end else begin
            d.fsm = ST_READ;
            d.req = 1'b1;
            d.we = 1'b0;
            d.addr = q.src_base;
            d.size = q.xfer_width_sel;
          end
        end
      end
      ST_READ: begin
        if (mem_ack) begin
          d.fsm = ST_WRITE;
          d.we = 1'b1;
          d.addr = q.cur_dst;
          d.wdata = mem_rdata;
        end
      end
      ST_WRITE: begin
        if (mem_ack) begin
          d.cur_src = next_addr(q.cur_src, q.src_hold, q.src_step_dir, q.xfer_width_sel);
          d.cur_dst = next_addr(q.cur_dst, q.dst_hold, q.dst_step_dir, q.xfer_width_sel);
          d.beat = q.beat + BEAT_W'(1);
          // One count is one item, or eight items in burst mode
          item_done = !q.burst8_en || (q.beat == LAST_BEAT);
          if (item_done) begin
            d.beat = '0;
            d.remain = q.remain - CNT_W'(1);
          end
          if (item_done && q.remain == CNT_W'(1)) begin
            d.fsm = ST_DONE;
            d.req = 1'b0;
            d.we = 1'b0;
          end else begin
            d.fsm = ST_READ;
            d.we = 1'b0;
            d.addr = d.cur_src;
          end
        end
      end
      ST_DONE: begin
        d.fsm = ST_IDLE;
        if (q.desc_mode && q.desc_irq_sel) begin
          d.irq = q.desc_last;
        end else begin
          d.irq = 1'b1;
        end
        // With re-init on, the enable stays and the channel restarts from the bases
        // A control write landing in this cycle keeps its own enable value, so a restart is not lost
        if (!q.auto_reinit_en && !(q.wr_pend && q.wr_ofs == OFS_CTRL)) begin
          d.channel_en = 1'b0;
        end
      end
      default: d.fsm = ST_IDLE;
    endcase

    // Disabling or resetting the channel aborts any operation in flight
    if (ch_reset || !d.channel_en) begin
      if (ch_reset) begin
        d.channel_en = 1'b0;
      end
      if (q.fsm != ST_DONE) begin
        d.fsm = ST_IDLE;
      end
      d.req = 1'b0;
      d.we = 1'b0;
    end

    d.src_mis = !d.src_step_dir && misaligned(d.src_base, d.xfer_width_sel);
    d.dst_mis = !d.dst_step_dir && misaligned(d.dst_base, d.xfer_width_sel);
    d.lock = d.bus_lock && (d.fsm != ST_IDLE);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.fsm <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // Single-cycle slave: every transfer completes with no wait state and an OKAY answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = q.rdata;
  assign mem_req = q.req;
  assign mem_we = q.we;
  assign mem_addr = q.addr;
  assign mem_size = q.size;
  assign mem_wdata = q.wdata;
  assign mem_lock = q.lock;
  assign xfer_irq = q.irq;
endmodule

/* File: hdl/dma_desc_pkg.sv */
// Constants, register map and types for the descriptor-mode DMA channel control block
// Contract
// - Source misalign flag, bit 22, set when source base is off the selected width.
// - Destination misalign flag, bit 21, uses the same word and half-word checks.
// - No source alignment check while the source address decrements.
// - No destination alignment check while the destination address decrements.
// - Both misalign flags are read-only; writes to them change nothing.
// - Bus lock bit 17 keeps the memory bus locked for the whole transfer.
// - Width field 13:12 moves byte, half-word or word per operation; 11 reserved.
// - Irq select bit 10: zero interrupts every descriptor, one only the last.
// - Irq select is honoured only in descriptor mode, ignored otherwise.
// - Source hold bit 7 keeps the source address constant.
// - Destination hold bit 6 keeps the destination address constant.
// - Source direction bit 5: zero increments, one decrements the source address.
// - Destination direction bit 4: zero increments, one decrements.
// - Burst bit 1 moves eight items per count; otherwise single items.
// - Without auto re-init, enable bit 0 clears itself when the transfer completes.
// - Outside descriptor mode the enable starts every kind of transfer.
// - In descriptor mode the enable starts only I/O-to-memory transfers.
// - A channel reset clears the enable bit.
// - Descriptor mode uses only a 14-bit transfer count.
package dma_desc_pkg;
  // Byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SRC_BASE = 8'h04;
  localparam logic [7:0] OFS_DST_BASE = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_CUR_SRC = 8'h10;
  localparam logic [7:0] OFS_CUR_DST = 8'h14;
  localparam logic [7:0] OFS_EXT = 8'h18;
  // Control register fields
  localparam int B_SRC_MIS = 22;
  localparam int B_DST_MIS = 21;
  localparam int B_AUTO = 19;
  localparam int B_LOCK = 17;
  localparam int B_WID_HI = 13;
  localparam int B_WID_LO = 12;
  localparam int B_IRQ_SEL = 10;
  localparam int B_SRC_HOLD = 7;
  localparam int B_DST_HOLD = 6;
  localparam int B_SRC_DIR = 5;
  localparam int B_DST_DIR = 4;
  localparam int B_MODE_HI = 3;
  localparam int B_MODE_LO = 2;
  localparam int B_BURST = 1;
  localparam int B_EN = 0;
  // Extension register fields
  localparam int B_DESC_MODE = 0;
  localparam int B_DESC_LAST = 1;
  localparam int B_KIND_LO = 2;
  localparam int B_KIND_HI = 3;
  localparam int B_CH_RESET = 4;
  localparam int B_BUSY = 8;
  localparam int COUNT_W = 24;
  localparam int DESC_COUNT_W = 14;
  localparam int BURST_ITEMS = 8;
  // Width codes
  localparam logic [1:0] WID_BYTE = 2'h0;
  localparam logic [1:0] WID_HALF = 2'h1;
  localparam logic [1:0] WID_WORD = 2'h2;
  localparam logic [1:0] WID_RSVD = 2'h3;
  // Transfer kinds
  localparam logic [1:0] KIND_M2M = 2'h0;
  localparam logic [1:0] KIND_M2IO = 2'h1;
  localparam logic [1:0] KIND_IO2M = 2'h2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] STEP_BYTE = 3'h1;
  localparam logic [2:0] STEP_HALF = 3'h2;
  localparam logic [2:0] STEP_WORD = 3'h4;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_DONE} fsm_t;
endpackage

/* File: test/dma_desc_ctrl_asserts.sv */
// Checker of memory-side sequencing and bus answers of the DMA channel control block
`timescale 1ns/1ns
module dma_desc_ctrl_chk
  import dma_desc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_lock,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic xfer_irq
);
  logic wr_q;
  logic [31:0] ctrl_q, rd_q, step, nxt_src;
  assign step = 32'h1 << ctrl_q[B_WID_HI:B_WID_LO];
  assign nxt_src = ctrl_q[B_SRC_HOLD] ? rd_q : ctrl_q[B_SRC_DIR] ? rd_q - step : rd_q + step;
  // Shadow of the control word, so memory-side checks know the programmed mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      ctrl_q <= RESET_WORD;
      rd_q <= 32'h0;
    end else begin
      wr_q <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite && haddr[7:0] == OFS_CTRL;
      if (wr_q) ctrl_q <= hwdata;
      if (mem_req && mem_ack && !mem_we) rd_q <= mem_addr;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_ack; mem_req && mem_ack && !mem_we; endsequence
  sequence s_wr_ack; mem_req && mem_ack && mem_we; endsequence
  property p_ready; $past(hresetn) |-> hreadyout; endproperty
  property p_lock; mem_req && mem_ack |-> mem_lock == ctrl_q[B_LOCK]; endproperty
  property p_size; mem_req && mem_ack |-> mem_size == ctrl_q[B_WID_HI:B_WID_LO]; endproperty
  // A channel reset may drop a pending request, so only a changed request is wrong
  property p_hold; mem_req && !mem_ack |=> !mem_req || $stable(mem_addr) && $stable(mem_we); endproperty
  property p_rd_wr; s_rd_ack |=> mem_req && mem_we && mem_wdata == $past(mem_rdata); endproperty
  property p_wr_rd; s_wr_ack |=> !(mem_req && mem_we); endproperty
  property p_src; s_wr_ack |=> !mem_req || mem_addr == nxt_src; endproperty
  property p_irq; xfer_irq |=> !xfer_irq; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  a_lock: assert property (p_lock) else $error("bus lock wrong");
  a_size: assert property (p_size) else $error("item size wrong");
  a_hold: assert property (p_hold) else $error("request changed");
  a_rd_wr: assert property (p_rd_wr) else $error("write after read wrong");
  a_wr_rd: assert property (p_wr_rd) else $error("two writes in a row");
  a_src: assert property (p_src) else $error("source step wrong");
  a_irq: assert property (p_irq) else $error("irq longer than a pulse");
endmodule

bind dma_desc_ctrl dma_desc_ctrl_chk chk_i (.*);

/* File: test/mem_partner.sv */
// Behavioural memory and peripheral model on the channel's memory side
`timescale 1ns/1ns
module mem_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [2:0] delay,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [2:0] wait_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      wait_q <= 3'h0;
      mem_rdata <= 32'h0;
    end else begin
      // Read data toggles outside the ack cycle so a late sample is caught
      mem_rdata <= ~mem_rdata;
      mem_ack <= 1'b0;
      if (!mem_req || mem_ack) begin
        wait_q <= 3'h0;
      end else if (wait_q == delay) begin
        mem_ack <= 1'b1;
        if (!mem_we) mem_rdata <= mem_addr ^ 32'h5a5a_a5a5;
      end else begin
        wait_q <= wait_q + 3'h1;
      end
    end
  end
endmodule

/* File: test/tb_dma_desc_ctrl.sv */
// Self-checking testbench of the DMA channel control block
`timescale 1ns/1ns
module tb_dma_desc_ctrl;
  import dma_desc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, desc_go;
  logic mem_req, mem_we, mem_lock, mem_ack, xfer_irq, mon_on;
  logic [1:0] htrans, mem_size;
  logic [2:0] hsize, delay;
  logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata, lfsr_q, rd, v, e, sa, da, st;
  logic [32:0] exp_q[$];
  logic [31:0] tc[6] = '{32'h0002_2410, 32'h1080, 32'h0062, 32'h2400, 32'h2400, 32'h2000};
  logic [31:0] tx[6] = '{32'h0, 32'h4, 32'h0, 32'h9, 32'h3, 32'h5};
  logic [31:0] tn[6] = '{32'h2, 32'h3, 32'h1, 32'h4001, 32'h2, 32'h1};
  logic [31:0] ts[6] = '{32'h1000, 32'h3002, 32'h5003, 32'h1100, 32'h1200, 32'h1300};
  logic [31:0] td[6] = '{32'h2000, 32'h4006, 32'h6007, 32'h2100, 32'h2200, 32'h2300};
  int tq[6] = '{1, 1, 1, 0, 1, 1};
  int num_errors, checks_done, irqs, cyc, n, k;
  assign hready = hreadyout;
  dma_desc_ctrl dma_desc_ctrl_i (.*);
  mem_partner mem_partner_i (.*);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic mis(input logic [1:0] w, input logic dir, input logic [1:0] a);
    return !dir && (w == WID_WORD && a != 2'h0 || w == WID_HALF && a[0]);
  endfunction
  task automatic check(input string nm, input logic [32:0] s, input logic [32:0] x);
    checks_done++;
    if (s !== x) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    rd = hrdata;
  endtask

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (xfer_irq === 1'b1) irqs++;
    if (mon_on && mem_req && mem_ack) check("access", {mem_we, mem_addr}, exp_q.pop_front());
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    {hresetn, hsel, hwrite, desc_go, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    delay = 3'h0;
    mon_on = 1'b1;
    lfsr_q = 32'hd30c;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, OFS_CTRL, 32'h0);
    check("ctrl reset", rd, RESET_WORD);
    check("okay", hresp, 1'b0);
    ahb(1'b1, 8'h1c, 32'hffff_ffff);
    ahb(1'b0, 8'h1c, 32'h0);
    check("unmapped", rd, 32'h0);
    for (int i = 0; i < 12; i++) begin
      lfsr_q = lfsr(lfsr_q);
      v = lfsr_q & 32'h000a_34fe;
      ahb(1'b1, OFS_CTRL, v | 32'h0060_0000);
      ahb(1'b1, OFS_SRC_BASE, lfsr_q >> 8);
      ahb(1'b1, OFS_DST_BASE, lfsr_q >> 16);
      @(posedge hclk);
      ahb(1'b0, OFS_CTRL, 32'h0);
      e = v;
      e[B_SRC_MIS] = mis(v[13:12], v[B_SRC_DIR], lfsr_q[9:8]);
      e[B_DST_MIS] = mis(v[13:12], v[B_DST_DIR], lfsr_q[17:16]);
      check("ctrl flags", rd, e);
    end
    // Aligned bases, counts in bursts when burst is on, burst off for peripherals
    for (int i = 0; i < 6; i++) begin
      lfsr_q = lfsr(lfsr_q);
      delay <= lfsr_q[2:0];
      k = irqs;
      sa = ts[i];
      da = td[i];
      st = 32'h1 << tc[i][13:12];
      n = (tx[i][0] ? tn[i][13:0] : tn[i][23:0]) * (tc[i][1] ? 8 : 1);
      for (int j = 0; j < n; j++) begin
        exp_q.push_back({1'b0, sa});
        exp_q.push_back({1'b1, da});
        if (!tc[i][7]) sa = tc[i][5] ? sa - st : sa + st;
        if (!tc[i][6]) da = tc[i][4] ? da - st : da + st;
      end
      ahb(1'b1, OFS_EXT, tx[i]);
      ahb(1'b1, OFS_SRC_BASE, ts[i]);
      ahb(1'b1, OFS_DST_BASE, td[i]);
      ahb(1'b1, OFS_COUNT, tn[i]);
      ahb(1'b1, OFS_CTRL, tc[i] | 32'h1);
      if (tx[i][0] && tx[i][3:2] != KIND_IO2M) begin
        repeat (4) @(posedge hclk);
        check("held", mem_req, 1'b0);
        desc_go <= 1'b1;
        @(posedge hclk);
        desc_go <= 1'b0;
      end
      while (exp_q.size() > 0) @(posedge hclk);
      repeat (4) @(posedge hclk);
      check("irqs", irqs - k, tq[i]);
      ahb(1'b0, OFS_CTRL, 32'h0);
      check("enable", rd[B_EN], 1'b0);
      ahb(1'b0, OFS_CUR_SRC, 32'h0);
      check("cur src", rd, sa);
      ahb(1'b0, OFS_CUR_DST, 32'h0);
      check("cur dst", rd, da);
      ahb(1'b0, OFS_EXT, 32'h0);
      check("ext", rd, tx[i]);
    end
    mon_on <= 1'b0;
    delay <= 3'h7;
    ahb(1'b1, OFS_EXT, 32'h0);
    ahb(1'b1, OFS_COUNT, 32'h5);
    ahb(1'b1, OFS_CTRL, 32'h3001);
    repeat (4) @(posedge hclk);
    check("reserved width", mem_req, 1'b0);
    ahb(1'b1, OFS_CTRL, 32'h2001);
    ahb(1'b1, OFS_EXT, 32'h10);
    ahb(1'b0, OFS_CTRL, 32'h0);
    check("reset enable", rd[B_EN], 1'b0);
    repeat (10) @(posedge hclk);
    check("reset idle", mem_req, 1'b0);
    conclude();
  end
endmodule
